// ===== verification/dcfrl_host.sv
`timescale 1ns/1ns
`default_nettype none
// Write-side and read-side host. Each transfer pulses only its own side's link clock, once, and both run freely only during reset.
module dcfrl_host (
   input wire logic ref_clk,
   output logic wr_clk,
   output logic rd_clk,
   output logic [8:0] data_in,
   output logic wen_n,
   output logic pin2,
   output logic rd_enable_primary_n,
   output logic rd_enable_secondary_n
);
   // Idle levels: clocks low, enables off, second write enable high.
   initial begin
      wr_clk = 1'b0;
      rd_clk = 1'b0;
      data_in = 9'h000;
      wen_n = 1'b1;
      pin2 = 1'b1;
      rd_enable_primary_n = 1'b1;
      rd_enable_secondary_n = 1'b1;
   end
   // Both clocks run during reset, ending low so release sees no edge.
   task automatic run_free(input int n);
      repeat (n) begin
         wr_clk <= 1'b1;
         rd_clk <= 1'b1;
         @(posedge ref_clk);
         wr_clk <= 1'b0;
         rd_clk <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   // Level of the shared pin; the device samples it while reset is high.
   task automatic set_pin2(input logic v);
      pin2 <= v;
   endtask
   // One link edge. Data and enables stand from before the rise until after
   // the fall; then data turns to its inverse so a stale word never looks valid.
   task automatic xfer(input logic w, input logic en, input logic [8:0] d);
      if (w) begin
         data_in <= d;
         wen_n <= !en;
      end else begin
         rd_enable_primary_n <= !en;
         rd_enable_secondary_n <= !en;
      end
      @(posedge ref_clk);
      wr_clk <= w;
      rd_clk <= !w;
      @(posedge ref_clk);
      wr_clk <= 1'b0;
      rd_clk <= 1'b0;
      @(posedge ref_clk);
      wen_n <= 1'b1;
      rd_enable_primary_n <= 1'b1;
      rd_enable_secondary_n <= 1'b1;
      data_in <= ~data_in;
      @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// ===== verification/dual_clock_fifo_flag_reset_logic_test.sv
`timescale 1ns/1ns
`default_nettype none
module dual_clock_fifo_flag_reset_logic_test;
   logic ref_clk, reset, oe_n, avs_read, avs_write, avs_waitrequest, irq;
   logic wr_clk, rd_clk, wen_n, pin2, rd_enable_primary_n, rd_enable_secondary_n, data_oe_n;
   logic full_flag_n, empty_flag_n, almost_empty_n;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [8:0] data_in, data_out;
   int n_mismatch = 0;
   int total_checks = 0;
   // Free-running system clock, 50 ns period.
   initial ref_clk = 1'b0;
   always #25 ref_clk = ~ref_clk;
   dcfrl_host host (.ref_clk(ref_clk), .wr_clk(wr_clk), .rd_clk(rd_clk),
      .data_in(data_in), .wen_n(wen_n), .pin2(pin2),
      .rd_enable_primary_n(rd_enable_primary_n),
      .rd_enable_secondary_n(rd_enable_secondary_n));
   // A depth of sixteen keeps the fill to full short.
   dcfrl_core #(.DEPTH(16)) DUT (.ref_clk(ref_clk), .reset(reset), .wr_clk(wr_clk),
      .rd_clk(rd_clk), .data_in(data_in), .wr_enable_primary_n(wen_n),
      .wr_enable2_or_load(pin2), .rd_enable_primary_n(rd_enable_primary_n),
      .rd_enable_secondary_n(rd_enable_secondary_n), .oe_n(oe_n), .data_out(data_out),
      .data_oe_n(data_oe_n), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
      .almost_empty_n(almost_empty_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One bus cycle held until waitrequest is seen low; a spare edge follows so
   // the strobe is never raised again in the step that dropped it.
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] wd);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= wd;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic chkreg(input logic [4:0] a, input logic [31:0] exp);
      av(1'b0, a, 32'h00000000);
      chk(rd, exp);
   endtask
   // Reset for twelve edges with both link clocks toggling inside it.
   task automatic do_reset(input logic p2);
      reset <= 1'b1;
      host.set_pin2(p2);
      host.run_free(5);
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_reset;
      do_reset(1'b1);
      chk(full_flag_n, 1'b1);
      chk(empty_flag_n, 1'b0);
      chk(data_oe_n, 1'b1);
      oe_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(data_oe_n, 1'b0);
      chk(data_out, 9'h000);
      chkreg(dcfrl_pkg::REG_EMPTY_OFFSET, 32'h00000007);
      chkreg(dcfrl_pkg::REG_FLAGS, 32'h00000001);
      chkreg(5'h14, 32'h00000000);
      $display("test reset done");
   endtask
   // First word: empty lifts on a read edge, the word comes on the next one.
   task automatic test_first;
      host.xfer(1'b1, 1'b1, 9'h1a5);
      repeat (10) @(posedge ref_clk);
      chk(empty_flag_n, 1'b0);
      host.xfer(1'b0, 1'b1, 9'h000);
      chk(empty_flag_n, 1'b1);
      chk(data_out, 9'h000);
      host.xfer(1'b0, 1'b1, 9'h000);
      chk(data_out, 9'h1a5);
      chk(empty_flag_n, 1'b0);
      av(1'b1, dcfrl_pkg::REG_MASK, 32'h00000000);
      av(1'b0, dcfrl_pkg::REG_EVENTS, 32'h00000000);
      chk(rd[4], 1'b1);
      chk(rd[1], 1'b1);
      chk(irq, 1'b0);
      av(1'b1, dcfrl_pkg::REG_MASK, 32'h00000010);
      chkreg(dcfrl_pkg::REG_MASK, 32'h00000010);
      repeat (2) @(posedge ref_clk);
      chk(irq, 1'b1);
      av(1'b1, dcfrl_pkg::REG_EVENTS, 32'h00000010);
      repeat (2) @(posedge ref_clk);
      chk(irq, 1'b0);
      $display("test first word done");
   endtask
   // Eight words against the default offset of seven, then drain in order.
   task automatic test_almost;
      for (int i = 0; i < 8; i++) host.xfer(1'b1, 1'b1, 9'h1f0 + 9'(i));
      host.xfer(1'b0, 1'b0, 9'h000);
      chk(almost_empty_n, 1'b1);
      chkreg(dcfrl_pkg::REG_LEVEL, 32'h00000008);
      for (int i = 0; i < 8; i++) begin
         host.xfer(1'b0, 1'b1, 9'h000);
         chk(data_out, 9'h1f0 + 9'(i));
         if (i < 2) chk(almost_empty_n, 1'(i == 0));
      end
      chk(empty_flag_n, 1'b0);
      av(1'b0, dcfrl_pkg::REG_EVENTS, 32'h00000000);
      chk(rd[2], 1'b1);
      $display("test almost empty done");
   endtask
   // Fill to full, try one more, and see full lift only on a write edge.
   task automatic test_full;
      for (int i = 0; i < 16; i++) begin
         host.xfer(1'b1, 1'b1, 9'h1f0 + 9'(i));
         if (i == 14) chk(full_flag_n, 1'b1);
      end
      chk(full_flag_n, 1'b0);
      host.xfer(1'b1, 1'b1, 9'h0aa);
      chkreg(dcfrl_pkg::REG_LEVEL, 32'h00000010);
      av(1'b0, dcfrl_pkg::REG_EVENTS, 32'h00000000);
      chk(rd[3], 1'b1);
      chk(rd[0], 1'b1);
      host.xfer(1'b0, 1'b0, 9'h000);
      host.xfer(1'b0, 1'b1, 9'h000);
      chk(data_out, 9'h1f0);
      chk(full_flag_n, 1'b0);
      host.xfer(1'b1, 1'b0, 9'h000);
      chk(full_flag_n, 1'b1);
      for (int i = 1; i < 16; i++) begin
         host.xfer(1'b0, 1'b1, 9'h000);
         chk(data_out, 9'h1f0 + 9'(i));
      end
      $display("test full done");
   endtask
   // Pin two low in reset turns a write strobe into an offset load.
   task automatic test_load;
      do_reset(1'b0);
      chkreg(dcfrl_pkg::REG_FLAGS, 32'h00000009);
      host.xfer(1'b1, 1'b1, 9'h003);
      chkreg(dcfrl_pkg::REG_EMPTY_OFFSET, 32'h00000003);
      chkreg(dcfrl_pkg::REG_LEVEL, 32'h00000000);
      do_reset(1'b1);
      chkreg(dcfrl_pkg::REG_EMPTY_OFFSET, 32'h00000007);
      $display("test load mode done");
   endtask
   // Main sequence; every input has a value at time zero.
   initial begin
      reset = 1'b1;
      oe_n = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h00;
      avs_writedata = 32'h00000000;
      test_reset;
      test_first;
      test_almost;
      test_full;
      test_load;
      stop_test;
   end
   // Watchdog: the whole run needs well under ten thousand cycles.
   initial begin
      #500000;
      n_mismatch++;
      stop_test;
   end
endmodule
`default_nettype wire

// ===== verilog/dcfrl_core.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Full release waits a write edge when read edge came too recently.
// - Empty release waits a read edge when write edge came too recently.
// - Reset works while both link clocks keep toggling.
// - After reset data reads low when enabled, floats when disabled.
// - Second write pin level at reset picks enable or offset load role.
// - First word appears the read cycle after empty goes high.
// - First-read latency exists only at empty, bounded by skew.
// - Almost-empty changes only if write edge preceded by partial skew.
// - Almost-empty goes low once words fall to offset minus one.
// - Full low when full, moves on write edges, blocks writes.
// - Empty low when empty, moves on read edges, blocks reads.
// - Empty offset is seven after reset.
module dcfrl_core #(
   parameter int DEPTH = dcfrl_pkg::DEPTH_DEFAULT
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic wr_clk,
   input wire logic rd_clk,
   input wire logic [8:0] data_in,
   input wire logic wr_enable_primary_n,
   input wire logic wr_enable2_or_load,
   input wire logic rd_enable_primary_n,
   input wire logic rd_enable_secondary_n,
   input wire logic oe_n,
   output logic [8:0] data_out,
   output logic data_oe_n,
   output logic full_flag_n,
   output logic empty_flag_n,
   output logic almost_empty_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic irq
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_P = (AW+1)'(DEPTH);

   // Refused at elaboration: the pointer wrap needs a power-of-two depth.
   if (DEPTH < 2 || (1 << AW) != DEPTH || AW + 1 > dcfrl_pkg::OFFSET_W) begin : g_depth_check
      $error("DEPTH must be a power of two from 2 up to the offset range");
   end

   // ----------------------------------------------------------------
   // FIFO state
   // ----------------------------------------------------------------
   logic wr_clk_prev, rd_clk_prev, load_mode;
   logic [3:0] wr_age, rd_age;
   logic [AW:0] wr_ptr, rd_ptr, wr_vis1, wr_vis2, rd_vis1;
   logic [dcfrl_pkg::OFFSET_W-1:0] empty_offset;
   logic [dcfrl_pkg::EV_W-1:0] events, mask;
   logic [8:0] ram_q;
   logic next_wr_clk_prev, next_rd_clk_prev, next_load_mode;
   logic [3:0] next_wr_age, next_rd_age;
   logic [AW:0] next_wr_ptr, next_rd_ptr, next_wr_vis1, next_wr_vis2, next_rd_vis1;
   logic [dcfrl_pkg::OFFSET_W-1:0] next_empty_offset;
   logic [dcfrl_pkg::EV_W-1:0] next_events, next_mask, ev_set;
   logic [8:0] next_data_out;
   logic next_data_oe_n, next_full_flag_n, next_empty_flag_n, next_almost_empty_n;
   logic next_irq;
   logic wr_rise, rd_rise, wr_go, rd_go, ld_go;
   logic [AW:0] wr_count, rd_count, pf_count;
   // Bus state.
   logic next_waitrequest;
   logic [31:0] next_readdata;
   logic bus_wr, bus_rd;

   assign wr_rise = wr_clk && !wr_clk_prev;
   assign rd_rise = rd_clk && !rd_clk_prev;
   // Writes store a word only with the second pin high.
   assign wr_go = wr_rise && !wr_enable_primary_n && wr_enable2_or_load
                  && full_flag_n;
   assign ld_go = wr_rise && !wr_enable_primary_n && !wr_enable2_or_load && load_mode;
   assign rd_go = rd_rise && !rd_enable_primary_n && !rd_enable_secondary_n
                  && empty_flag_n;
   assign bus_wr = avs_write && !avs_waitrequest;
   assign bus_rd = avs_read && avs_waitrequest;

   dcfrl_ram #(.DEPTH(DEPTH), .AW(AW)) u_ram (
      .ref_clk(ref_clk),
      .wr_en(wr_go),
      .wr_addr(wr_ptr[AW-1:0]),
      .wr_data(data_in),
      .rd_addr(rd_ptr[AW-1:0]),
      .rd_data(ram_q)
   );

   // ----------------------------------------------------------------
   // Next-state computation
   // ----------------------------------------------------------------
   // Pointer copies cross sides only after the skew time has passed since
   // the owning edge, so a flag never sees a pointer that just moved.
   always_comb begin
      next_wr_clk_prev = wr_clk;
      next_rd_clk_prev = rd_clk;
      next_load_mode = load_mode;
      next_wr_ptr = wr_ptr + (AW+1)'(wr_go);
      next_rd_ptr = rd_ptr + (AW+1)'(rd_go);
      next_wr_age = wr_rise ? 4'h0 : (wr_age == dcfrl_pkg::AGE_MAX ? wr_age : wr_age + 4'h1);
      next_rd_age = rd_rise ? 4'h0 : (rd_age == dcfrl_pkg::AGE_MAX ? rd_age : rd_age + 4'h1);
      next_wr_vis1 = (wr_age >= dcfrl_pkg::SKEW1_CYC) ? wr_ptr : wr_vis1;
      next_wr_vis2 = (wr_age >= dcfrl_pkg::SKEW2_CYC) ? wr_ptr : wr_vis2;
      next_rd_vis1 = (rd_age >= dcfrl_pkg::SKEW1_CYC) ? rd_ptr : rd_vis1;
      wr_count = next_wr_ptr - rd_vis1;
      rd_count = wr_vis1 - next_rd_ptr;
      pf_count = wr_vis2 - next_rd_ptr;
      // Flags move only on their own side's edge.
      next_full_flag_n = wr_rise ? (wr_count != DEPTH_P) : full_flag_n;
      next_empty_flag_n = rd_rise ? (rd_count != '0) : empty_flag_n;
      next_almost_empty_n = almost_empty_n;
      if (rd_rise) begin
         // Low once at most n-1 words remain.
         next_almost_empty_n = (dcfrl_pkg::OFFSET_W'(pf_count) >= empty_offset);
      end
      // A read only happens once empty is high, so the first word lands
      // one read edge after empty rises, never sooner.
      next_data_out = rd_go ? ram_q : data_out;
      next_data_oe_n = oe_n;
      next_empty_offset = empty_offset;
      if (ld_go) begin
         next_empty_offset = dcfrl_pkg::OFFSET_W'(data_in);
      end else if (bus_wr && avs_address == dcfrl_pkg::REG_EMPTY_OFFSET) begin
         next_empty_offset = avs_writedata[dcfrl_pkg::OFFSET_W-1:0];
      end
      next_mask = (bus_wr && avs_address == dcfrl_pkg::REG_MASK) ?
                  avs_writedata[dcfrl_pkg::EV_W-1:0] : mask;
      ev_set = '0;
      ev_set[dcfrl_pkg::EV_FULL] = full_flag_n && !next_full_flag_n;
      ev_set[dcfrl_pkg::EV_EMPTY] = empty_flag_n && !next_empty_flag_n;
      ev_set[dcfrl_pkg::EV_ALMOST] = almost_empty_n && !next_almost_empty_n;
      ev_set[dcfrl_pkg::EV_WR_REFUSED] = wr_rise && !wr_enable_primary_n
                                         && wr_enable2_or_load && !full_flag_n;
      ev_set[dcfrl_pkg::EV_RD_REFUSED] = rd_rise && !rd_enable_primary_n
                                         && !rd_enable_secondary_n && !empty_flag_n;
      next_events = events;
      if (bus_wr && avs_address == dcfrl_pkg::REG_EVENTS) begin
         next_events = events & ~avs_writedata[dcfrl_pkg::EV_W-1:0];
      end
      // A new event beats a clear in the same cycle.
      next_events = next_events | ev_set;
      next_irq = |(next_events & next_mask);
   end

   // ----------------------------------------------------------------
   // FIFO registers
   // ----------------------------------------------------------------
   // Reset is synchronous to ref_clk, so a running link clock during
   // reset is merely sampled and cannot disturb the cleared state.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wr_clk_prev <= 1'b0;
         rd_clk_prev <= 1'b0;
         // The strap is caught on every reset cycle; the last one wins.
         load_mode <= !wr_enable2_or_load;
         wr_age <= dcfrl_pkg::AGE_MAX;
         rd_age <= dcfrl_pkg::AGE_MAX;
         wr_ptr <= '0;
         rd_ptr <= '0;
         wr_vis1 <= '0;
         wr_vis2 <= '0;
         rd_vis1 <= '0;
         full_flag_n <= 1'b1;
         empty_flag_n <= 1'b0;
         almost_empty_n <= 1'b0;
         data_out <= dcfrl_pkg::DATA_RESET;
         data_oe_n <= 1'b1;
         empty_offset <= dcfrl_pkg::EMPTY_OFFSET_RESET;
         events <= '0;
         mask <= '0;
         irq <= 1'b0;
      end else begin
         wr_clk_prev <= next_wr_clk_prev;
         rd_clk_prev <= next_rd_clk_prev;
         load_mode <= next_load_mode;
         wr_age <= next_wr_age;
         rd_age <= next_rd_age;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         wr_vis1 <= next_wr_vis1;
         wr_vis2 <= next_wr_vis2;
         rd_vis1 <= next_rd_vis1;
         full_flag_n <= next_full_flag_n;
         empty_flag_n <= next_empty_flag_n;
         almost_empty_n <= next_almost_empty_n;
         data_out <= next_data_out;
         data_oe_n <= next_data_oe_n;
         empty_offset <= next_empty_offset;
         events <= next_events;
         mask <= next_mask;
         irq <= next_irq;
      end
   end

   // ----------------------------------------------------------------
   // Avalon-MM slave
   // ----------------------------------------------------------------
   // Fixed one wait cycle: read data is latched while waitrequest is
   // high, so it is settled in the cycle waitrequest drops.
   always_comb begin
      next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
      next_readdata = avs_readdata;
      if (bus_rd) begin
         next_readdata = 32'h0000_0000;
         unique case (avs_address)
            dcfrl_pkg::REG_FLAGS: begin
               next_readdata[dcfrl_pkg::FL_FULL_N] = full_flag_n;
               next_readdata[dcfrl_pkg::FL_EMPTY_N] = empty_flag_n;
               next_readdata[dcfrl_pkg::FL_ALMOST_N] = almost_empty_n;
               next_readdata[dcfrl_pkg::FL_LOAD_MODE] = load_mode;
            end
            dcfrl_pkg::REG_EVENTS: next_readdata[dcfrl_pkg::EV_W-1:0] = events;
            dcfrl_pkg::REG_MASK: next_readdata[dcfrl_pkg::EV_W-1:0] = mask;
            dcfrl_pkg::REG_EMPTY_OFFSET: begin
               next_readdata[dcfrl_pkg::OFFSET_W-1:0] = empty_offset;
            end
            dcfrl_pkg::REG_LEVEL: next_readdata[AW:0] = wr_ptr - rd_ptr;
            default: next_readdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= next_waitrequest;
         avs_readdata <= next_readdata;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   a_full_own_edge: assert property ($changed(full_flag_n) |-> $past(wr_rise))
      else $error("full flag moved without a write edge");
   a_no_write_full: assert property (!full_flag_n && wr_rise |=> wr_ptr == $past(wr_ptr))
      else $error("write pointer moved while full");
   a_empty_own_edge: assert property ($changed(empty_flag_n) |-> $past(rd_rise))
      else $error("empty flag moved without a read edge");
   a_no_read_empty: assert property (!empty_flag_n && rd_rise |=> rd_ptr == $past(rd_ptr))
      else $error("read pointer moved while empty");
   a_vis_settled: assert property ($changed(wr_vis1)
      |-> $past(wr_age) >= dcfrl_pkg::SKEW1_CYC)
      else $error("write pointer copy taken too early");
   a_rd_vis_settled: assert property ($changed(rd_vis1)
      |-> $past(rd_age) >= dcfrl_pkg::SKEW1_CYC)
      else $error("read pointer copy taken too early");
   a_almost_own_edge: assert property ($changed(almost_empty_n) |-> $past(rd_rise))
      else $error("almost empty moved without a read edge");
   a_offset_default: assert property ($fell(reset)
      |-> empty_offset == dcfrl_pkg::EMPTY_OFFSET_RESET)
      else $error("empty offset not at its default after reset");
   a_strap_caught: assert property ($fell(reset)
      |-> load_mode == !$past(wr_enable2_or_load))
      else $error("load mode strap not taken from the reset level");
   // The pin copy lags one cycle; a cycle spent in reset forces the float level.
   a_oe_follows: assert property (data_oe_n == ($past(reset) ? 1'b1 : $past(oe_n)))
      else $error("output enable did not follow its pin");
   a_first_word: assert property ($rose(empty_flag_n) |-> data_out == $past(data_out))
      else $error("data changed in the cycle empty rose");
   // Read data stands until the next accepted read.
   a_data_hold: assert property (!$past(rd_go) |-> $stable(data_out))
      else $error("read data changed without a read");
   // A write edge with the second write pin low must never store a word.
   a_load_no_store: assert property (wr_rise && !wr_enable2_or_load
      |=> wr_ptr == $past(wr_ptr))
      else $error("word stored while the second write pin was low");
   // The level never passes the depth, so a missed full flag shows up here.
   a_level_cap: assert property ((wr_ptr - rd_ptr) <= DEPTH_P)
      else $error("fill level beyond depth");

   // Bus replies take one wait cycle and stand for one cycle only.
   a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("bus reply did not come after one wait cycle");
   a_bus_reply_once: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("bus reply stood for more than one cycle");
   a_bus_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
      else $error("bus answered with no request");

   // A new event stays set even when software clears it in the same cycle,
   // and the interrupt is a level view of the unmasked sticky bits.
   a_event_sticky: assert property ((|ev_set) |=> (events & $past(ev_set)) == $past(ev_set))
      else $error("event bit lost");
   a_irq_level: assert property (irq == |(events & mask))
      else $error("interrupt level disagrees with status and mask");

   // ----------------------------------------------------------------
   // Cover points
   // ----------------------------------------------------------------
   c_fill_full: cover property ($fell(full_flag_n));
   c_empty_exit: cover property ($rose(empty_flag_n) ##[1:40] rd_go);
   c_almost_low: cover property ($fell(almost_empty_n));
   c_irq: cover property ($rose(irq));
   c_load_offset: cover property (ld_go);
endmodule
`default_nettype wire

// ===== verilog/dcfrl_pkg.sv
package dcfrl_pkg;
   // ----------------------------------------------------------------
   // Timing figures and derived cycle counts
   // ----------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS = 50;
   localparam int FULL_EMPTY_SKEW_MIN_NS = 5;
   localparam int PARTIAL_FLAG_SKEW_MIN_NS = 10;
   // Least times round up, and never below one cycle.
   localparam int SKEW1_RAW = (FULL_EMPTY_SKEW_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int SKEW2_RAW = (PARTIAL_FLAG_SKEW_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam logic [3:0] SKEW1_CYC = 4'(SKEW1_RAW < 1 ? 1 : SKEW1_RAW);
   localparam logic [3:0] SKEW2_CYC = 4'(SKEW2_RAW < 1 ? 1 : SKEW2_RAW);
   localparam logic [3:0] AGE_MAX = 4'hf;

   // ----------------------------------------------------------------
   // Sizes and reset values
   // ----------------------------------------------------------------
   localparam int DATA_W = 9;
   localparam int DEPTH_DEFAULT = 16384;
   localparam int OFFSET_W = 18;
   localparam logic [17:0] EMPTY_OFFSET_RESET = 18'h00007;
   localparam logic [8:0] DATA_RESET = 9'h000;

   // ----------------------------------------------------------------
   // Register map (byte addresses) and field positions
   // ----------------------------------------------------------------
   localparam logic [4:0] REG_FLAGS = 5'h00;
   localparam logic [4:0] REG_EVENTS = 5'h04;
   localparam logic [4:0] REG_MASK = 5'h08;
   localparam logic [4:0] REG_EMPTY_OFFSET = 5'h0c;
   localparam logic [4:0] REG_LEVEL = 5'h10;
   localparam int EV_W = 5;
   localparam int EV_FULL = 0;
   localparam int EV_EMPTY = 1;
   localparam int EV_ALMOST = 2;
   localparam int EV_WR_REFUSED = 3;
   localparam int EV_RD_REFUSED = 4;
   localparam int FL_FULL_N = 0;
   localparam int FL_EMPTY_N = 1;
   localparam int FL_ALMOST_N = 2;
   localparam int FL_LOAD_MODE = 3;
endpackage

// ===== verilog/dcfrl_ram.sv
`timescale 1ns/1ns
`default_nettype none
// Storage array: one write port, one combinational read port.
module dcfrl_ram #(
   parameter int DEPTH = 16384,
   parameter int AW = 14
) (
   input wire logic ref_clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [dcfrl_pkg::DATA_W-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [dcfrl_pkg::DATA_W-1:0] rd_data
);
   logic [dcfrl_pkg::DATA_W-1:0] mem [DEPTH];

   // ----------------------------------------------------------------
   // Write and read
   // ----------------------------------------------------------------
   // The array is not reset; the empty flag keeps stale words unseen.
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   assign rd_data = mem[rd_addr];
endmodule
`default_nettype wire
